// ---- src/bdc_regs.sv ----
// control and status registers of the backlight dimming controller
`timescale 1ns/1ns
module bdc_regs #(
  parameter int unsigned TURN_ON_CYCLES = bdc_pkg::TURN_ON_CYCLES_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire bdc_pkg::bdc_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire bdc_pkg::bdc_fault_t fault_in,
  input wire logic external_duty_input,
  output logic [7:0] applied_duty,
  output logic channel_drive_en,
  output logic [bdc_pkg::NUM_CH-1:0] channel_readout
);
  import bdc_pkg::*;

  logic [7:0] duty_level_r, duty_level_nxt;
  logic [7:0] ctl_r, ctl_nxt;
  logic err_r, err_nxt;
  bdc_lamp_t lamp_r, lamp_nxt;
  logic [ON_CNT_W-1:0] on_cnt_r, on_cnt_nxt;
  logic [7:0] applied_r, applied_nxt;
  logic drive_r, drive_nxt;
  logic [NUM_CH-1:0] readout_r, readout_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [7:0] meas_duty;
  logic meas_update;
  logic wr_duty, wr_ctl, wr_flags, lamp_toggle, err_cause, one_down, two_down;
  logic lamp_on_state;
  logic [3:0] down_cnt;
  logic [15:0] prod;
  logic [15:0] scaled;
  logic [7:0] flags;

  bdc_duty_meter u_meter (
    .core_clk(core_clk),
    .rst(rst),
    .external_duty_input(external_duty_input),
    .meas_duty(meas_duty),
    .meas_update(meas_update)
  );

  // fault summary
  always_comb begin
    down_cnt = 4'h0;
    for (int i = 0; i < NUM_CH; i++) begin
      down_cnt = down_cnt + {3'b000, fault_in.ch_faulted[i]};
    end
    one_down = (down_cnt != 4'h0);
    two_down = (down_cnt >= TWO_CH_MIN);
    err_cause = fault_in.overtemp | fault_in.overcurrent | one_down | two_down;
    lamp_on_state = (lamp_r == LAMP_ON);
    flags = 8'h00;
    flags[FLG_SUMMARY_ERR] = err_r;
    flags[FLG_OVERTEMP] = fault_in.overtemp;
    flags[FLG_OVERCURRENT] = fault_in.overcurrent;
    flags[FLG_LAMP_STATE] = lamp_on_state;
    flags[FLG_ONE_CH] = one_down;
    flags[FLG_TWO_CH] = two_down;
  end

  // register writes and reads
  always_comb begin
    wr_duty = reg_req.wr && reg_req.addr == OFS_DUTY_LEVEL;
    wr_ctl = reg_req.wr && reg_req.addr == OFS_BACKLIGHT_CONTROL;
    wr_flags = reg_req.wr && reg_req.addr == OFS_ERROR_AND_STATE_FLAGS;
    lamp_toggle = wr_ctl && (reg_req.wdata[CTL_LAMP_ON] != ctl_r[CTL_LAMP_ON]);
    duty_level_nxt = wr_duty ? reg_req.wdata : duty_level_r;
    ctl_nxt = wr_ctl ? reg_req.wdata : ctl_r;
    err_nxt = err_r;
    if (lamp_toggle || (wr_flags && !reg_req.wdata[FLG_SUMMARY_ERR])) err_nxt = 1'b0;
    if (err_cause) err_nxt = 1'b1;
    rvalid_nxt = reg_req.rd;
    rdata_nxt = rdata_r;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        OFS_DUTY_LEVEL: rdata_nxt = duty_level_r;
        OFS_BACKLIGHT_CONTROL: rdata_nxt = ctl_r;
        OFS_ERROR_AND_STATE_FLAGS: rdata_nxt = flags;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // lamp sequencing
  always_comb begin
    lamp_nxt = lamp_r;
    on_cnt_nxt = on_cnt_r;
    if (!ctl_r[CTL_LAMP_ON]) begin
      lamp_nxt = LAMP_OFF;
      on_cnt_nxt = '0;
    end else begin
      unique case (lamp_r)
        LAMP_OFF: begin
          lamp_nxt = LAMP_RAMP;
          on_cnt_nxt = '0;
        end
        LAMP_RAMP: begin
          on_cnt_nxt = on_cnt_r + 1'b1;
          if (on_cnt_r >= ON_CNT_W'(TURN_ON_CYCLES - 3)) lamp_nxt = LAMP_ON;
        end
        LAMP_ON: lamp_nxt = LAMP_ON;
        default: lamp_nxt = LAMP_OFF;
      endcase
    end
  end

  // applied duty per source and method
  always_comb begin
    prod = duty_level_r * meas_duty;
    scaled = (prod + 16'h0001 + {8'h00, prod[15:8]}) >> 8;
    if (ctl_r[CTL_SOURCE_SEL]) applied_nxt = meas_duty;
    else if (ctl_r[CTL_METHOD_SEL]) applied_nxt = duty_level_r;
    else applied_nxt = scaled[7:0];
    if (!lamp_on_state) applied_nxt = DUTY_ZERO;
    drive_nxt = lamp_on_state && (applied_nxt != DUTY_ZERO);
    readout_nxt = lamp_on_state ? (fault_in.ch_enabled & ~fault_in.ch_faulted) : '0;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      duty_level_r <= RST_DUTY_LEVEL;
      ctl_r <= RST_BACKLIGHT_CONTROL;
      err_r <= RST_FLAGS[FLG_SUMMARY_ERR];
      lamp_r <= LAMP_OFF;
      on_cnt_r <= '0;
      applied_r <= DUTY_ZERO;
      drive_r <= 1'b0;
      readout_r <= '0;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      duty_level_r <= duty_level_nxt;
      ctl_r <= ctl_nxt;
      err_r <= err_nxt;
      lamp_r <= lamp_nxt;
      on_cnt_r <= on_cnt_nxt;
      applied_r <= applied_nxt;
      drive_r <= drive_nxt;
      readout_r <= readout_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign applied_duty = applied_r;
  assign channel_drive_en = drive_r;
  assign channel_readout = readout_r;

  // helper: cycles since the lamp command went high, saturating at the top bit
  logic [ON_CNT_W:0] since_on_r;
  always_ff @(posedge core_clk) begin
    if (rst || !ctl_r[CTL_LAMP_ON]) since_on_r <= '0;
    else if (!since_on_r[ON_CNT_W]) since_on_r <= since_on_r + 1'b1;
  end

  property p_reset_values;
    @(posedge core_clk) $rose(!rst) |-> duty_level_r == RST_DUTY_LEVEL && ctl_r == RST_BACKLIGHT_CONTROL && !err_r;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

  property p_on_deadline;
    @(posedge core_clk) disable iff (rst) (since_on_r >= (ON_CNT_W+1)'(TURN_ON_CYCLES)) |-> lamp_on_state;
  endproperty
  a_on_deadline: assert property (p_on_deadline) else $error("lamp late to turn on");

  property p_off_now;
    @(posedge core_clk) disable iff (rst) wr_ctl && !reg_req.wdata[CTL_LAMP_ON] |=> ##2 !channel_drive_en && channel_readout == '0 && !lamp_on_state;
  endproperty
  a_off_now: assert property (p_off_now) else $error("lamp not off after clear");

  property p_err_sticky;
    @(posedge core_clk) disable iff (rst) err_r && !lamp_toggle && !(wr_flags && !reg_req.wdata[FLG_SUMMARY_ERR]) |=> err_r;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped");

  property p_err_set;
    @(posedge core_clk) disable iff (rst) (fault_in.overtemp || fault_in.overcurrent || fault_in.ch_faulted != '0) |=> err_r;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flag not set");

  property p_err_clear;
    @(posedge core_clk) disable iff (rst) wr_flags && !reg_req.wdata[FLG_SUMMARY_ERR] && !err_cause |=> !err_r;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error flag not cleared");

  property p_ext_source;
    @(posedge core_clk) disable iff (rst) lamp_on_state && ctl_r[CTL_SOURCE_SEL] && ctl_nxt == ctl_r |=> applied_duty == $past(meas_duty);
  endproperty
  a_ext_source: assert property (p_ext_source) else $error("input source ignored");

  property p_reg_method;
    @(posedge core_clk) disable iff (rst) lamp_on_state && ctl_r[2:1] == 2'b10 |=> applied_duty == $past(duty_level_r);
  endproperty
  a_reg_method: assert property (p_reg_method) else $error("register method wrong");

  property p_duty_readback;
    @(posedge core_clk) disable iff (rst) wr_duty ##1 (reg_req.rd && reg_req.addr == OFS_DUTY_LEVEL && !reg_req.wr) |=> reg_rdata == $past(reg_req.wdata, 2);
  endproperty
  a_duty_readback: assert property (p_duty_readback) else $error("duty readback wrong");

  property p_flag_reserved;
    @(posedge core_clk) disable iff (rst) reg_req.rd && reg_req.addr == OFS_ERROR_AND_STATE_FLAGS |=> reg_rdata[7:6] == 2'b00;
  endproperty
  a_flag_reserved: assert property (p_flag_reserved) else $error("reserved flags nonzero");

  property p_zero_disconnect;
    @(posedge core_clk) disable iff (rst) applied_duty == DUTY_ZERO |-> !channel_drive_en;
  endproperty
  a_zero_disconnect: assert property (p_zero_disconnect) else $error("zero duty still drives");

  // lamp not on: nothing applied and nothing shown in the readout
  property p_off_applied;
    @(posedge core_clk) disable iff (rst) !lamp_on_state |=> applied_duty == DUTY_ZERO;
  endproperty
  a_off_applied: assert property (p_off_applied) else $error("duty applied while off");

  property p_off_readout;
    @(posedge core_clk) disable iff (rst) !lamp_on_state |=> channel_readout == '0;
  endproperty
  a_off_readout: assert property (p_off_readout) else $error("readout nonzero while off");

  property p_cmd_off_state;
    @(posedge core_clk) disable iff (rst) !ctl_r[CTL_LAMP_ON] |=> !lamp_on_state;
  endproperty
  a_cmd_off_state: assert property (p_cmd_off_state) else $error("lamp state on without command");

  property p_on_readout;
    @(posedge core_clk) disable iff (rst) lamp_on_state |=> channel_readout == (($past(fault_in.ch_enabled)) & ~($past(fault_in.ch_faulted)));
  endproperty
  a_on_readout: assert property (p_on_readout) else $error("readout wrong while on");

  c_turn_on: cover property (@(posedge core_clk) disable iff (rst) $rose(lamp_on_state));
  c_combined: cover property (@(posedge core_clk) disable iff (rst) lamp_on_state && ctl_r[2:1] == 2'b00 && meas_update);
  c_err_toggle: cover property (@(posedge core_clk) disable iff (rst) err_r && lamp_toggle);
  c_two_down: cover property (@(posedge core_clk) disable iff (rst) two_down && lamp_on_state);
endmodule

// ---- pkg/bdc_pkg.sv ----
// shared constants and carriers for the backlight dimming control registers
package bdc_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TURN_ON_MAX_MS = 4;
  localparam int unsigned TURN_ON_CYCLES_DEF = TURN_ON_MAX_MS * 1000 * CLK_MHZ;
  localparam int unsigned ON_CNT_W = 20;

  localparam logic [7:0] OFS_DUTY_LEVEL = 8'h00;
  localparam logic [7:0] OFS_BACKLIGHT_CONTROL = 8'h01;
  localparam logic [7:0] OFS_ERROR_AND_STATE_FLAGS = 8'h02;

  localparam logic [7:0] RST_DUTY_LEVEL = 8'hff;
  localparam logic [7:0] RST_BACKLIGHT_CONTROL = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] DUTY_MAX = 8'hff;
  localparam logic [7:0] DUTY_ZERO = 8'h00;

  // backlight_control fields
  localparam int unsigned CTL_LAMP_ON = 0;
  localparam int unsigned CTL_SOURCE_SEL = 1;
  localparam int unsigned CTL_METHOD_SEL = 2;

  // error_and_state_flags fields
  localparam int unsigned FLG_SUMMARY_ERR = 0;
  localparam int unsigned FLG_OVERTEMP = 1;
  localparam int unsigned FLG_OVERCURRENT = 2;
  localparam int unsigned FLG_LAMP_STATE = 3;
  localparam int unsigned FLG_ONE_CH = 4;
  localparam int unsigned FLG_TWO_CH = 5;

  localparam int unsigned NUM_CH = 6;
  localparam int unsigned MEAS_CNT_W = 16;
  localparam int unsigned DIV_STEPS = 8;
  localparam logic [3:0] TWO_CH_MIN = 4'h2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bdc_req_t;

  typedef struct packed {
    logic overtemp;
    logic overcurrent;
    logic [NUM_CH-1:0] ch_faulted;
    logic [NUM_CH-1:0] ch_enabled;
  } bdc_fault_t;

  typedef enum logic [2:0] {
    LAMP_OFF = 3'b001,
    LAMP_RAMP = 3'b010,
    LAMP_ON = 3'b100
  } bdc_lamp_t;
endpackage

// ---- src/bdc_duty_meter.sv ----
// measures the high-time fraction of the external duty input as an 8-bit value
`timescale 1ns/1ns
module bdc_duty_meter (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic external_duty_input,
  output logic [7:0] meas_duty,
  output logic meas_update
);
  import bdc_pkg::*;
  logic in_d_r, in_d_nxt;
  logic [MEAS_CNT_W-1:0] per_cnt_r, per_cnt_nxt, hi_cnt_r, hi_cnt_nxt;
  logic [MEAS_CNT_W-1:0] den_r, den_nxt;
  logic [MEAS_CNT_W+7:0] rem_r, rem_nxt;
  logic [7:0] quo_r, quo_nxt, meas_r, meas_nxt;
  logic [3:0] step_r, step_nxt;
  logic busy_r, busy_nxt, upd_r, upd_nxt;
  logic rise;
  logic [MEAS_CNT_W+7:0] trial;

  always_comb begin
    rise = external_duty_input & ~in_d_r;
    in_d_nxt = external_duty_input;
    per_cnt_nxt = per_cnt_r;
    hi_cnt_nxt = hi_cnt_r;
    den_nxt = den_r;
    rem_nxt = rem_r;
    quo_nxt = quo_r;
    meas_nxt = meas_r;
    step_nxt = step_r;
    busy_nxt = busy_r;
    upd_nxt = 1'b0;
    trial = {rem_r[MEAS_CNT_W+6:0], 1'b0};
    // saturating counters over one input period, rising edge to rising edge
    if (rise) begin
      per_cnt_nxt = {{(MEAS_CNT_W-1){1'b0}}, 1'b1};
      hi_cnt_nxt = {{(MEAS_CNT_W-1){1'b0}}, 1'b1};
      if (!busy_r && per_cnt_r != '0) begin
        busy_nxt = 1'b1;
        den_nxt = per_cnt_r;
        rem_nxt = {8'h00, hi_cnt_r};
        quo_nxt = 8'h00;
        step_nxt = 4'h0;
      end
    end else begin
      if (~&per_cnt_r) per_cnt_nxt = per_cnt_r + 1'b1;
      if (external_duty_input && ~&hi_cnt_r) hi_cnt_nxt = hi_cnt_r + 1'b1;
    end
    // restoring division: fraction = high / period, 8 fractional bits
    if (busy_r) begin
      if (trial >= {8'h00, den_r}) begin
        rem_nxt = trial - {8'h00, den_r};
        quo_nxt = {quo_r[6:0], 1'b1};
      end else begin
        rem_nxt = trial;
        quo_nxt = {quo_r[6:0], 1'b0};
      end
      step_nxt = step_r + 1'b1;
      if (step_r == 4'(DIV_STEPS - 1)) begin
        busy_nxt = 1'b0;
        upd_nxt = 1'b1;
        // a full-high input gives hi == per, saturate at full scale
        meas_nxt = (rem_r >= {8'h00, den_r}) ? DUTY_MAX : quo_nxt;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      in_d_r <= 1'b0;
      per_cnt_r <= '0;
      hi_cnt_r <= '0;
      den_r <= '0;
      rem_r <= '0;
      quo_r <= 8'h00;
      meas_r <= DUTY_ZERO;
      step_r <= 4'h0;
      busy_r <= 1'b0;
      upd_r <= 1'b0;
    end else begin
      in_d_r <= in_d_nxt;
      per_cnt_r <= per_cnt_nxt;
      hi_cnt_r <= hi_cnt_nxt;
      den_r <= den_nxt;
      rem_r <= rem_nxt;
      quo_r <= quo_nxt;
      meas_r <= meas_nxt;
      step_r <= step_nxt;
      busy_r <= busy_nxt;
      upd_r <= upd_nxt;
    end
  end

  assign meas_duty = meas_r;
  assign meas_update = upd_r;
endmodule

// ---- dv/bdc_pwm_src.sv ----
// external duty input source driving the block's pwm pin
`timescale 1ns/1ns
module bdc_pwm_src (
  input wire logic core_clk,
  input wire logic run,
  input wire logic [15:0] period_cyc,
  input wire logic [15:0] high_cyc,
  output logic duty_pin
);
  logic [15:0] cnt_r;
  always_ff @(posedge core_clk) begin
    if (!run || cnt_r >= period_cyc - 16'h1) begin
      cnt_r <= 16'h0;
    end else begin
      cnt_r <= cnt_r + 16'h1;
    end
  end
  // idle low between runs, as a pulled-down input would sit
  assign duty_pin = run && (cnt_r < high_cyc);
endmodule

// ---- dv/testbench.sv ----
// self-checking bench for the backlight dimming control registers
`timescale 1ns/1ns
module testbench;
  import bdc_pkg::*;
  localparam int unsigned TON = 20;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  bdc_req_t reg_req = '0;
  bdc_fault_t fault_in = '0;
  logic pwm_run = 1'b1;
  logic [15:0] hi = 16'h1e;
  logic duty_pin;
  logic [7:0] reg_rdata;
  logic [7:0] applied_duty;
  logic reg_rvalid;
  logic channel_drive_en;
  logic [NUM_CH-1:0] channel_readout;
  logic [7:0] rd_v;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int duty_m = 255;
  int ctl_m = 0;
  int err_m = 0;
  int meas_m = 0;
  logic [7:0] modes [4] = '{8'h05, 8'h01, 8'h03, 8'h07};

  bdc_regs #(.TURN_ON_CYCLES(TON)) bdc_regs_inst (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fault_in(fault_in), .external_duty_input(duty_pin),
    .applied_duty(applied_duty), .channel_drive_en(channel_drive_en), .channel_readout(channel_readout));
  bdc_pwm_src bdc_pwm_src_inst (.core_clk(core_clk), .run(pwm_run), .period_cyc(16'h64), .high_cyc(hi),
    .duty_pin(duty_pin));

  always #2 core_clk = ~core_clk;

  task automatic test_done();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_c(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge core_clk);
    #1 reg_req = '0;
    if (!w) begin
      chk("rvalid", 8'h01, {7'h0, reg_rvalid});
      rd_v = reg_rdata;
    end
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(name, exp, rd_v);
  endtask

  // reference model of the register side effects
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    if (a == OFS_DUTY_LEVEL) duty_m = d;
    if (a == OFS_BACKLIGHT_CONTROL) begin
      if (d[0] != ctl_m[0]) err_m = 0;
      ctl_m = d;
    end
    if (a == OFS_ERROR_AND_STATE_FLAGS && !d[0]) err_m = 0;
    if (fault_in.overtemp || fault_in.overcurrent || fault_in.ch_faulted != '0) err_m = 1;
  endtask

  function automatic logic [7:0] exp_applied();
    if (!ctl_m[0]) return 8'h00;
    if (ctl_m[1]) return 8'(meas_m);
    if (ctl_m[2]) return 8'(duty_m);
    return 8'(duty_m * meas_m / 255);
  endfunction

  function automatic logic [7:0] exp_flags();
    int nf;
    nf = $countones(fault_in.ch_faulted);
    return {2'b00, nf >= 2, nf >= 1, ctl_m[0] == 1, fault_in.overcurrent, fault_in.overtemp, err_m == 1};
  endfunction

  task automatic chk_out();
    logic [7:0] a;
    a = exp_applied();
    chk("applied_duty", a, applied_duty);
    chk("drive_en", {7'h0, a != 8'h00}, {7'h0, channel_drive_en});
    chk("readout", ctl_m[0] ? {2'b00, fault_in.ch_enabled & ~fault_in.ch_faulted} : 8'h00, {2'b00, channel_readout});
    rd_chk("flags", OFS_ERROR_AND_STATE_FLAGS, exp_flags());
  endtask

  initial begin
    void'($urandom(32'hedfe));
    repeat (20) @(posedge core_clk);
    #1 rst = 1'b0;
    rd_chk("duty_rst", OFS_DUTY_LEVEL, RST_DUTY_LEVEL);
    rd_chk("ctl_rst", OFS_BACKLIGHT_CONTROL, RST_BACKLIGHT_CONTROL);
    rd_chk("flags_rst", OFS_ERROR_AND_STATE_FLAGS, RST_FLAGS);
    rd_chk("unmapped", 8'h05, 8'h00);
    chk_out();
    wr_reg(OFS_ERROR_AND_STATE_FLAGS, 8'hfe);
    rd_chk("flags_ro", OFS_ERROR_AND_STATE_FLAGS, 8'h00);
    wr_reg(OFS_BACKLIGHT_CONTROL, 8'hf8);
    rd_chk("ctl_rsv", OFS_BACKLIGHT_CONTROL, 8'hf8);
    chk_out();
    fault_in.ch_enabled = 6'($urandom);
    wr_reg(OFS_BACKLIGHT_CONTROL, 8'h05);
    wait_c(TON + 4);
    chk_out();
    // every dimming mode with boundary and random duty levels
    for (int m = 0; m < 4; m++) begin
      hi = 16'(1 + $urandom % 99);
      meas_m = 256 * hi / 100;
      wr_reg(OFS_BACKLIGHT_CONTROL, modes[m]);
      wait_c(300);
      for (int i = 0; i < 3; i++) begin
        wr_reg(OFS_DUTY_LEVEL, (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom));
        wait_c(12);
        rd_chk("duty_rb", OFS_DUTY_LEVEL, 8'(duty_m));
        chk_out();
      end
    end
    // back-to-back write then read of the duty level
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: OFS_DUTY_LEVEL, wdata: 8'h5a};
    @(posedge core_clk);
    #1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: OFS_DUTY_LEVEL, wdata: 8'h00};
    @(posedge core_clk);
    #1 reg_req = '0;
    duty_m = 8'h5a;
    chk("duty_b2b", 8'(duty_m), reg_rdata);
    fault_in.overtemp = 1'b1;
    err_m = 1;
    wait_c(3);
    chk_out();
    fault_in.overtemp = 1'b0;
    wait_c(3);
    chk_out();
    wr_reg(OFS_ERROR_AND_STATE_FLAGS, 8'h00);
    chk_out();
    for (int k = 0; k < 3; k++) begin
      fault_in.overcurrent = (k == 0);
      fault_in.ch_faulted = (k == 1) ? 6'h04 : (k == 2) ? 6'h21 : 6'h00;
      err_m = 1;
      wait_c(3);
      chk_out();
      wr_reg(OFS_ERROR_AND_STATE_FLAGS, 8'h00);
      chk_out();
      fault_in.overcurrent = 1'b0;
      fault_in.ch_faulted = 6'h00;
      wr_reg(OFS_ERROR_AND_STATE_FLAGS, 8'h00);
      chk_out();
    end
    fault_in.overtemp = 1'b1;
    err_m = 1;
    wait_c(3);
    fault_in.overtemp = 1'b0;
    wr_reg(OFS_BACKLIGHT_CONTROL, 8'h04);
    wait_c(3);
    chk_out();
    wr_reg(OFS_BACKLIGHT_CONTROL, 8'h05);
    wait_c(TON + 4);
    chk_out();
    test_done();
  end
endmodule
